//--- verilog/tmr8_pkg.sv
// Purpose: Constants, field layouts and state types of the 8-bit timer.
// Assumes: Registers are reached over APB, one aligned 32-bit word each.
// Notes:   Every module of the timer writes its names as tmr8_pkg::name.
//
// Behaviour
// - Force bit copies output level to pin.
// - Forced transfer sets no compare flag.
// - Force bits ignored in pulse modes.
// - One-pulse trigger: preset, level two, flag, capture.
// - One-pulse compare one match ends pulse.
// - One-pulse: compare flag one never set.
// - Both mode bits set means pulse-width mode.
// - Equal levels give a constant pin.
// - One-pulse: input one never captures.
// - One-pulse: compare two drives no waveform.
// - Pulse-width compares buffered until period end.
// - Pulse-width compare two match presets counter.
// - Pulse-width pin takes level one, two.
// - Pulse-width mode sets no compare flags.
// - Pulse-width period end sets capture flag one.
// - Pulse-width: input one disconnected, two captures.
// - Wait mode: timer runs, interrupt wakes.
// - Halt stops counter, resumes held count.
// - Halt edge arms capture, taken at exit.
// - Five flags share one gated interrupt.
// - Capture flag clears: status read, access.
// - Two-bit select picks timer clock divider.
// - Overflow flag set on wrap to zero.
package tmr8_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_CTRL2  = 8'h00;
  localparam logic [7:0] OFF_CTRL1  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CAPT1  = 8'h0c;
  localparam logic [7:0] OFF_CMP1   = 8'h10;
  localparam logic [7:0] OFF_COUNT  = 8'h14;
  localparam logic [7:0] OFF_CAPT2  = 8'h18;
  localparam logic [7:0] OFF_CMP2   = 8'h1c;

  // Counter and capture values.
  localparam logic [7:0]  COUNT_RESET    = 8'hfc;
  localparam logic [7:0]  COUNT_PRESET   = 8'hfc;
  localparam logic [7:0]  COUNT_TOP      = 8'hff;
  localparam logic [7:0]  CMP_RESET      = 8'h00;
  localparam logic [15:0] OPM_CAPT_VALUE = 16'hfffd;

  // Prescaler terminal counts, one less than each divide factor.
  localparam logic [12:0] DIV_END_4    = 13'h0003;
  localparam logic [12:0] DIV_END_2    = 13'h0001;
  localparam logic [12:0] DIV_END_8    = 13'h0007;
  localparam logic [12:0] DIV_END_8000 = 13'h1f3f;
  localparam logic [1:0]  SEL_DIV_4    = 2'h0;
  localparam logic [1:0]  SEL_DIV_2    = 2'h1;
  localparam logic [1:0]  SEL_DIV_8    = 2'h2;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_ONE_PULSE, MODE_PWM}
    tmr8_mode_type;

  typedef struct packed {
    logic captureIrqEnable;
    logic compareIrqEnable;
    logic overflowIrqEnable;
    logic forceLevel2;
    logic forceLevel1;
    logic outputLevel2;
    logic captureEdgeSelect1;
    logic outputLevel1;
  } tmr8_ctrl1_type;

  typedef struct packed {
    logic       comparePinEnable1;
    logic       comparePinEnable2;
    logic       onePulseSelect;
    logic       pwmSelect;
    logic [1:0] clockDividerSelect;
    logic       captureEdgeSelect2;
    logic       reserved;
  } tmr8_ctrl2_type;

  typedef struct packed {
    logic       captureFlag1;
    logic       compareFlag1;
    logic       overflowFlag;
    logic       captureFlag2;
    logic       compareFlag2;
    logic [2:0] reserved;
  } tmr8_status_type;

  typedef struct packed {
    tmr8_ctrl1_type  ctrl1;
    tmr8_ctrl2_type  ctrl2;
    tmr8_status_type status;
    tmr8_status_type arm;
    logic [7:0]      count;
    logic [7:0]      cmpWritten1;
    logic [7:0]      cmpWritten2;
    logic [7:0]      cmpActive1;
    logic [7:0]      cmpActive2;
    logic [15:0]     capt1;
    logic [7:0]      capt2;
    logic            haltArm1;
    logic            haltArm2;
    logic            haltDelay;
    logic            pin1;
    logic            pin1Oe;
    logic            pin2;
    logic            pin2Oe;
    logic            irq;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } tmr8_state_type;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic pulse;
  } tmr8_sync_state_type;

  typedef struct packed {
    logic [12:0] count;
    logic        tick;
  } tmr8_presc_state_type;

endpackage

//--- verilog/tmr8_prescaler.sv
// Purpose: Timer clock prescaler giving a one-cycle count tick.
// Assumes: The oscillator clock for the slowest setting is sys_clk.
// Notes:   A change of select takes effect at once; a count already at or past the new end ticks next cycle.
`timescale 1ns/1ps
module tmr8_prescaler (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] divSelect,
  output logic            tick
);

  tmr8_pkg::tmr8_presc_state_type s;
  tmr8_pkg::tmr8_presc_state_type next_s;

  // Terminal count for each select code.
  function automatic logic [12:0] divEnd(input logic [1:0] sel);
    case (sel)
      tmr8_pkg::SEL_DIV_4: divEnd = tmr8_pkg::DIV_END_4;
      tmr8_pkg::SEL_DIV_2: divEnd = tmr8_pkg::DIV_END_2;
      tmr8_pkg::SEL_DIV_8: divEnd = tmr8_pkg::DIV_END_8;
      default:             divEnd = tmr8_pkg::DIV_END_8000;
    endcase
  endfunction

  // Count up and pulse once per divide period.
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.count >= divEnd(divSelect)) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + 13'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

//--- verilog/tmr8_edge_sync.sv
// Purpose: Synchronise a capture pin and flag its selected edge.
// Assumes: The pin is asynchronous to sys_clk.
// Notes:   Edge pulse comes three cycles after the pin moves.
`timescale 1ns/1ps
module tmr8_edge_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  input  wire logic risingSel,
  output logic      edgePulse
);

  tmr8_pkg::tmr8_sync_state_type s;
  tmr8_pkg::tmr8_sync_state_type next_s;

  // The first stage feeds only the second, to contain metastability.
  always_comb begin
    next_s = s;
    next_s.sync1 = pinIn;
    next_s.sync2 = s.sync1;
    next_s.last = s.sync2;
    next_s.pulse = (s.sync2 != s.last) && (s.sync2 == risingSel);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign edgePulse = s.pulse;

endmodule

//--- verilog/tmr8_timer.sv
// Purpose: 8-bit timer with forced output, one-pulse and PWM modes.
// Assumes: haltMode and cpuMask come from logic on sys_clk.
// Notes:   APB answers with one wait state; irq also wakes from wait.
`timescale 1ns/1ps
module tmr8_timer (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        captureInPin1,
  input  wire logic        captureInPin2,
  input  wire logic        haltMode,
  input  wire logic        cpuMask,
  output logic             compareOutPin1,
  output logic             compareOutPin1Oe,
  output logic             compareOutPin2,
  output logic             compareOutPin2Oe,
  output logic             timerIrq
);

  tmr8_pkg::tmr8_state_type  s;
  tmr8_pkg::tmr8_state_type  next_s;
  tmr8_pkg::tmr8_mode_type   mode;
  tmr8_pkg::tmr8_status_type setF;
  tmr8_pkg::tmr8_status_type clrF;
  logic tick;
  logic edge1;
  logic edge2;
  logic access;
  logic wr;
  logic rd;
  logic wrCount;
  logic tickRun;
  logic match1;
  logic match2;
  logic wrap;
  logic opmTrig;
  logic capEvent1;
  logic capEvent2;
  logic haltExit;
  logic pwmEnd;

  // Decode of a register offset during the access phase.
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Zero extension of a byte register onto the read bus.
  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h000000, v};
  endfunction

  tmr8_prescaler uPresc (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .divSelect (s.ctrl2.clockDividerSelect),
    .tick      (tick)
  );

  tmr8_edge_sync uEdge1 (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pinIn     (captureInPin1),
    .risingSel (s.ctrl1.captureEdgeSelect1),
    .edgePulse (edge1)
  );

  tmr8_edge_sync uEdge2 (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pinIn     (captureInPin2),
    .risingSel (s.ctrl2.captureEdgeSelect2),
    .edgePulse (edge2)
  );

  // Mode select: PWM wins when both select bits are set.
  always_comb begin
    if (s.ctrl2.pwmSelect) begin
      mode = tmr8_pkg::MODE_PWM;
    end else if (s.ctrl2.onePulseSelect) begin
      mode = tmr8_pkg::MODE_ONE_PULSE;
    end else begin
      mode = tmr8_pkg::MODE_NORMAL;
    end
  end

  // Bus strobes; a transfer completes when pready is seen high.
  assign access = psel && penable && s.pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign wrCount = wr && hit(paddr, tmr8_pkg::OFF_COUNT);

  // Counter events. Halt freezes counting, wait does not touch it.
  assign tickRun = tick && !haltMode;
  assign match1 = tickRun && (s.count == s.cmpActive1);
  assign match2 = tickRun && (s.count == s.cmpActive2);
  assign pwmEnd = (mode == tmr8_pkg::MODE_PWM) && match2;
  // A preset or a counter write at FFh is not a wrap to 00h.
  assign wrap = tickRun && (s.count == tmr8_pkg::COUNT_TOP) && !pwmEnd
                && !opmTrig && !wrCount;
  assign opmTrig = (mode == tmr8_pkg::MODE_ONE_PULSE) && edge1
                   && !haltMode;
  assign capEvent1 = (mode == tmr8_pkg::MODE_NORMAL) && edge1
                     && !haltMode;
  assign capEvent2 = edge2 && !haltMode;
  assign haltExit = s.haltDelay && !haltMode;

  // Hardware flag sets per mode.
  always_comb begin
    setF = '0;
    setF.captureFlag1 = capEvent1 || opmTrig || pwmEnd
                        || (haltExit && s.haltArm1);
    setF.captureFlag2 = capEvent2 || (haltExit && s.haltArm2);
    setF.compareFlag1 = match1 && (mode == tmr8_pkg::MODE_NORMAL);
    setF.compareFlag2 = match2 && (mode != tmr8_pkg::MODE_PWM);
    setF.overflowFlag = wrap;
  end

  // Two-step clear: an armed flag drops on access to its register.
  always_comb begin
    clrF = '0;
    if (access) begin
      clrF.captureFlag1 = s.arm.captureFlag1
                          && hit(paddr, tmr8_pkg::OFF_CAPT1);
      clrF.captureFlag2 = s.arm.captureFlag2
                          && hit(paddr, tmr8_pkg::OFF_CAPT2);
      clrF.compareFlag1 = s.arm.compareFlag1
                          && hit(paddr, tmr8_pkg::OFF_CMP1);
      clrF.compareFlag2 = s.arm.compareFlag2
                          && hit(paddr, tmr8_pkg::OFF_CMP2);
      clrF.overflowFlag = s.arm.overflowFlag
                          && hit(paddr, tmr8_pkg::OFF_COUNT);
    end
  end

  // Next state of the whole timer.
  always_comb begin
    next_s = s;
    // Set wins over clear so no event is lost.
    next_s.status = tmr8_pkg::tmr8_status_type'((s.status & ~clrF) | setF);
    next_s.arm = tmr8_pkg::tmr8_status_type'(s.arm & ~clrF);
    if (rd && hit(paddr, tmr8_pkg::OFF_STATUS)) begin
      next_s.arm = tmr8_pkg::tmr8_status_type'(s.arm | s.status);
    end
    // Register writes.
    if (wr) begin
      case (paddr)
        tmr8_pkg::OFF_CTRL1: next_s.ctrl1 = pwdata[7:0];
        tmr8_pkg::OFF_CTRL2: begin
          next_s.ctrl2 = pwdata[7:0];
          next_s.ctrl2.reserved = 1'b0;
        end
        tmr8_pkg::OFF_CMP1:  next_s.cmpWritten1 = pwdata[7:0];
        tmr8_pkg::OFF_CMP2:  next_s.cmpWritten2 = pwdata[7:0];
        default: ;
      endcase
    end
    // PWM holds new compares until the period ends, avoiding spikes.
    if (mode != tmr8_pkg::MODE_PWM || pwmEnd) begin
      next_s.cmpActive1 = next_s.cmpWritten1;
      next_s.cmpActive2 = next_s.cmpWritten2;
    end
    // Counter.
    if (wrCount) begin
      next_s.count = tmr8_pkg::COUNT_RESET;
    end else if (opmTrig || pwmEnd) begin
      next_s.count = tmr8_pkg::COUNT_PRESET;
    end else if (tickRun) begin
      next_s.count = s.count + 8'h01;
    end
    // Captures; halt only arms and takes the count at exit.
    next_s.haltDelay = haltMode;
    if (haltMode && edge1 && mode == tmr8_pkg::MODE_NORMAL) begin
      next_s.haltArm1 = 1'b1;
    end
    if (haltMode && edge2) begin
      next_s.haltArm2 = 1'b1;
    end
    if (capEvent1 || (haltExit && s.haltArm1)) begin
      next_s.capt1 = {8'h00, s.count};
    end else if (opmTrig) begin
      next_s.capt1 = tmr8_pkg::OPM_CAPT_VALUE;
    end
    if (capEvent2 || (haltExit && s.haltArm2)) begin
      next_s.capt2 = s.count;
    end
    if (haltExit) begin
      next_s.haltArm1 = 1'b0;
      next_s.haltArm2 = 1'b0;
    end
    // Compare pin 1 waveform.
    if (mode != tmr8_pkg::MODE_NORMAL) begin
      if (s.ctrl1.outputLevel1 == s.ctrl1.outputLevel2) begin
        next_s.pin1 = s.ctrl1.outputLevel1;
      end else if (opmTrig || pwmEnd) begin
        next_s.pin1 = s.ctrl1.outputLevel2;
      end else if (match1) begin
        next_s.pin1 = s.ctrl1.outputLevel1;
      end
    end else if (s.ctrl1.forceLevel1 || match1) begin
      next_s.pin1 = s.ctrl1.outputLevel1;
    end
    // Compare pin 2 stays put outside normal mode.
    if (mode == tmr8_pkg::MODE_NORMAL) begin
      if (s.ctrl1.forceLevel2 || match2) begin
        next_s.pin2 = s.ctrl1.outputLevel2;
      end
    end
    next_s.pin1Oe = s.ctrl2.comparePinEnable1;
    next_s.pin2Oe = s.ctrl2.comparePinEnable2;
    // One request for all five flags; no wait gating, so it wakes.
    next_s.irq = !cpuMask && (
      ((s.status.captureFlag1 || s.status.captureFlag2)
        && s.ctrl1.captureIrqEnable)
      || ((s.status.compareFlag1 || s.status.compareFlag2)
        && s.ctrl1.compareIrqEnable)
      || (s.status.overflowFlag && s.ctrl1.overflowIrqEnable));
    // APB answer: one wait state, then pready for one cycle.
    next_s.pready = psel && penable && !s.pready;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready) begin
      next_s.prdata = '0;
      case (paddr)
        tmr8_pkg::OFF_CTRL1:  next_s.prdata = word8(s.ctrl1);
        tmr8_pkg::OFF_CTRL2:  next_s.prdata = word8(s.ctrl2);
        tmr8_pkg::OFF_STATUS: next_s.prdata = word8(s.status);
        tmr8_pkg::OFF_CAPT1:  next_s.prdata = {16'h0000, s.capt1};
        tmr8_pkg::OFF_CMP1:   next_s.prdata = word8(s.cmpWritten1);
        tmr8_pkg::OFF_COUNT:  next_s.prdata = word8(s.count);
        tmr8_pkg::OFF_CAPT2:  next_s.prdata = word8(s.capt2);
        tmr8_pkg::OFF_CMP2:   next_s.prdata = word8(s.cmpWritten2);
        default:              next_s.pslverr = 1'b1;
      endcase
    end
  end

  // State register; the pin latches start low.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.count <= tmr8_pkg::COUNT_RESET;
      s.cmpWritten1 <= tmr8_pkg::CMP_RESET;
      s.cmpWritten2 <= tmr8_pkg::CMP_RESET;
      s.cmpActive1 <= tmr8_pkg::CMP_RESET;
      s.cmpActive2 <= tmr8_pkg::CMP_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign compareOutPin1 = s.pin1;
  assign compareOutPin1Oe = s.pin1Oe;
  assign compareOutPin2 = s.pin2;
  assign compareOutPin2Oe = s.pin2Oe;
  assign timerIrq = s.irq;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  force_pin_a: assert property (
    (mode == tmr8_pkg::MODE_NORMAL) && s.ctrl1.forceLevel1
    |=> s.pin1 == $past(s.ctrl1.outputLevel1))
    else $error("Forced level did not reach compare pin one.");

  force_noflag_a: assert property (
    s.ctrl1.forceLevel1 && !match1 && !s.status.compareFlag1
    |=> !s.status.compareFlag1)
    else $error("Forced transfer set compare flag one.");

  opm_trigger_a: assert property (
    opmTrig && !wrCount
    |=> s.count == tmr8_pkg::COUNT_PRESET
        && s.capt1 == tmr8_pkg::OPM_CAPT_VALUE && s.status.captureFlag1)
    else $error("One-pulse trigger did not preset and capture.");

  opm_end_a: assert property (
    (mode == tmr8_pkg::MODE_ONE_PULSE) && match1 && !opmTrig
    |=> s.pin1 == $past(s.ctrl1.outputLevel1))
    else $error("One-pulse compare match did not end the pulse.");

  pulse_noflag_a: assert property (
    (mode != tmr8_pkg::MODE_NORMAL) && !s.status.compareFlag1
    |=> !s.status.compareFlag1)
    else $error("Compare flag one set in a pulse mode.");

  pwm_reload_a: assert property (
    pwmEnd && !wrCount
    |=> s.count == tmr8_pkg::COUNT_PRESET && s.status.captureFlag1)
    else $error("PWM period end did not preset the counter.");

  pwm_buffer_a: assert property (
    (mode == tmr8_pkg::MODE_PWM) && !pwmEnd && $stable(mode)
    |=> $stable(s.cmpActive1) && $stable(s.cmpActive2))
    else $error("PWM compare changed inside a period.");

  irq_gate_a: assert property (
    !cpuMask && s.status.overflowFlag && s.ctrl1.overflowIrqEnable
    |=> timerIrq)
    else $error("Enabled overflow raised no interrupt.");

  irq_mask_a: assert property (
    cpuMask |=> !timerIrq)
    else $error("Interrupt raised while masked.");

  halt_freeze_a: assert property (
    haltMode && !wrCount |=> $stable(s.count))
    else $error("Counter moved during halt.");

  overflow_set_a: assert property (
    wrap |=> s.status.overflowFlag)
    else $error("Wrap did not set the overflow flag.");

  // Between its own events a pulse-mode pin must ignore the force bits.
  force_ignored_a: assert property (
    (mode != tmr8_pkg::MODE_NORMAL) && !opmTrig && !pwmEnd && !match1
    && (s.ctrl1.outputLevel1 != s.ctrl1.outputLevel2)
    |=> $stable(s.pin1))
    else $error("Compare pin one moved without a pulse event.");

  equal_level_a: assert property (
    (mode != tmr8_pkg::MODE_NORMAL)
    && (s.ctrl1.outputLevel1 == s.ctrl1.outputLevel2)
    |=> s.pin1 == $past(s.ctrl1.outputLevel1))
    else $error("Equal levels did not hold compare pin one.");

  pwm_period_a: assert property (
    pwmEnd && (s.ctrl1.outputLevel1 != s.ctrl1.outputLevel2)
    |=> s.pin1 == $past(s.ctrl1.outputLevel2))
    else $error("PWM period end did not apply level two.");

  pwm_noflag_a: assert property (
    (mode == tmr8_pkg::MODE_PWM) && !s.status.compareFlag2
    |=> !s.status.compareFlag2)
    else $error("Compare flag two set in PWM mode.");

  halt_capture_a: assert property (
    haltExit && s.haltArm2
    |=> s.status.captureFlag2 && s.capt2 == $past(s.count))
    else $error("Armed capture two not taken at halt exit.");

  opm_seen_c: cover property (opmTrig ##[1:300] match1);
  pwm_seen_c: cover property (pwmEnd ##[1:300] pwmEnd);
  halt_seen_c: cover property (haltExit && s.haltArm1);
  clear_seen_c: cover property (clrF.captureFlag1);
  halt_capt_c: cover property (haltExit && s.haltArm2);

endmodule

//--- tb/tmr8_pin_model.sv
// Purpose: Far-side pins: capture sources and compare pin wire levels.
// Assumes: Compare pins carry pull-ups while the timer releases them.
// Notes:   Capture levels move only just after a rising sys_clk edge.
`timescale 1ns/1ps
module tmr8_pin_model (
  input  wire logic sys_clk,
  input  wire logic srcLevel1,
  input  wire logic srcLevel2,
  input  wire logic pinOut1,
  input  wire logic pinOe1,
  input  wire logic pinOut2,
  input  wire logic pinOe2,
  output logic      captureInPin1,
  output logic      captureInPin2,
  output logic      padLevel1,
  output logic      padLevel2
);
  // Registered sources, so an edge never lands on a sampling edge.
  always_ff @(posedge sys_clk) begin
    captureInPin1 <= srcLevel1;
    captureInPin2 <= srcLevel2;
  end
  // A released pin floats up to the pull-up, never to the last level.
  assign padLevel1 = pinOe1 ? pinOut1 : 1'b1;
  assign padLevel2 = pinOe2 ? pinOut2 : 1'b1;
endmodule

//--- tb/timer_pulse_modes_and_events_tb_top.sv
// Purpose: Self-checking bench for the 8-bit pulse and event timer.
// Assumes: APB master tasks wait for pready; no fixed slave latency.
// Notes:   Divide-by-2 keeps the pulse scenarios short.
`timescale 1ns/1ps
module timer_pulse_modes_and_events_tb_top;
  localparam logic [7:0] C2 = tmr8_pkg::OFF_CTRL2;
  localparam logic [7:0] C1 = tmr8_pkg::OFF_CTRL1;
  localparam logic [7:0] ST = tmr8_pkg::OFF_STATUS;
  localparam logic [7:0] K1 = tmr8_pkg::OFF_CMP1;
  localparam logic [7:0] K2 = tmr8_pkg::OFF_CMP2;
  logic        sys_clk  = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        haltMode = 1'b0;
  logic        cpuMask  = 1'b0;
  logic        lev1     = 1'b0;
  logic        lev2     = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cap1;
  logic        cap2;
  logic        out1;
  logic        oe1;
  logic        out2;
  logic        oe2;
  logic        pad1;
  logic        pad2;
  logic        timerIrq;
  logic [31:0] rdat;
  logic [31:0] hold;
  logic        rerr;
  int          cyc;
  int          error_cnt  = 0;
  int          num_checks = 0;

  // The clock toggles every half period of 5 ns.
  always #5 sys_clk = ~sys_clk;

  tmr8_timer u_tmr8_timer (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .captureInPin1(cap1), .captureInPin2(cap2), .haltMode(haltMode),
    .cpuMask(cpuMask), .compareOutPin1(out1), .compareOutPin1Oe(oe1),
    .compareOutPin2(out2), .compareOutPin2Oe(oe2), .timerIrq(timerIrq));

  tmr8_pin_model u_tmr8_pin_model (.sys_clk(sys_clk), .srcLevel1(lev1),
    .srcLevel2(lev2), .pinOut1(out1), .pinOe1(oe1), .pinOut2(out2),
    .pinOe2(oe2), .captureInPin1(cap1), .captureInPin2(cap2),
    .padLevel1(pad1), .padLevel2(pad2));

  // Every comparison is counted; a miss is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Bounded wait for the compare pin wire; cyc returns the wait.
  task automatic wait_pin(input logic lvl, input int lim);
    cyc = 0;
    while (pad1 !== lvl && cyc < lim) begin
      @(posedge sys_clk);
      cyc++;
    end
    chk({31'h0, pad1}, {31'h0, lvl});
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A hang is cut short well beyond the thousand or so cycles needed.
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  // Main sequence of scenarios.
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ST);
    chk(rdat, 32'h0);
    wr(C2, 32'h8c);
    rd(C1);
    chk(rdat, 32'h0);
    rd(K1);
    chk(rdat, 32'h0);
    rd(K2);
    chk(rdat, 32'h0);
    rd(8'h20);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    // Forced level follows the level bit, with no compare flag.
    wr(C1, 32'h09);
    wait_pin(1'b1, 6);
    wr(C1, 32'h08);
    wait_pin(1'b0, 6);
    // Pin two: released, then driven low, then forced up and down.
    chk({31'h0, pad2}, 32'h1);
    wr(C2, 32'hcc);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, pad2}, 32'h0);
    wr(C1, 32'h14);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, pad2}, 32'h1);
    wr(C1, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, pad2}, 32'h0);
    rd(ST);
    chk(rdat & 32'h48, 32'h0);
    // One-pulse: trigger on input one, capture on input two.
    wr(K1, 32'h10);
    wr(C1, 32'h06);
    wr(C2, 32'ha6);
    lev1 <= 1'b1;
    lev2 <= 1'b1;
    wait_pin(1'b1, 12);
    rd(ST);
    chk(rdat & 32'hd0, 32'h90);
    rd(tmr8_pkg::OFF_CAPT1);
    chk(rdat, 32'h0000fffd);
    rd(ST);
    chk(rdat & 32'hc0, 32'h0);
    wait_pin(1'b0, 100);
    // Pulse-width mode with level one high and level two low.
    wr(K1, 32'h20);
    wr(K2, 32'h40);
    wr(C1, 32'h89);
    wr(C2, 32'h96);
    lev1 <= 1'b0;
    wait_pin(1'b1, 400);
    wait_pin(1'b0, 400);
    wait_pin(1'b1, 400);
    wait_pin(1'b0, 400);
    chk(cyc, 32'd64);
    rd(ST);
    rd(tmr8_pkg::OFF_CAPT2);
    wr(K1, 32'h30);
    wr(K2, 32'h40);
    lev2 <= 1'b0;
    wait_pin(1'b1, 400);
    wait_pin(1'b0, 400);
    lev2 <= 1'b1;
    wait_pin(1'b1, 400);
    wait_pin(1'b0, 400);
    chk(cyc, 32'd32);
    rd(ST);
    chk(rdat & 32'hd8, 32'h90);
    chk({31'h0, timerIrq}, 32'h1);
    cpuMask <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, timerIrq}, 32'h0);
    cpuMask <= 1'b0;
    // Equal levels: the pin stays high over more than one period.
    wr(C1, 32'h85);
    cyc = 0;
    repeat (150) begin
      @(posedge sys_clk);
      if (pad1 === 1'b1) begin
        cyc++;
      end
    end
    chk(cyc, 32'd150);
    // Halt freezes the counter; a capture edge only arms.
    haltMode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(tmr8_pkg::OFF_COUNT);
    hold = rdat;
    rd(ST);
    rd(tmr8_pkg::OFF_CAPT2);
    lev2 <= 1'b0;
    repeat (5) @(posedge sys_clk);
    lev2 <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rd(tmr8_pkg::OFF_COUNT);
    chk(rdat, hold);
    rd(ST);
    chk(rdat & 32'h10, 32'h0);
    haltMode <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(ST);
    chk(rdat & 32'h10, 32'h10);
    rd(tmr8_pkg::OFF_CAPT2);
    chk(rdat, hold);
    report_and_stop();
  end
endmodule
